// [shared/pnd_pkg.sv]
package pnd_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int PND_ADDR_W = 8;
    localparam int PND_DATA_W = 32;
    localparam int PND_GROUPS = 4;
    localparam int PND_SEL_W = 2;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PND_OFF_HIGH = 8'h00;
    localparam logic [7:0] PND_OFF_LOW = 8'h04;
    localparam logic [7:0] PND_OFF_HIGH_UPPER = 8'h08;
    localparam logic [7:0] PND_OFF_HIGH_LOWER = 8'h0c;
    localparam logic [7:0] PND_OFF_LOW_UPPER = 8'h10;
    localparam logic [7:0] PND_OFF_LOW_LOWER = 8'h14;
    localparam logic [7:0] PND_OFF_ENABLE = 8'h18;
    localparam logic [7:0] PND_OFF_TRIG_SEL = 8'h1c;
    localparam logic [7:0] PND_OFF_MODE = 8'h20;
    localparam logic [7:0] PND_OFF_OUTPUT = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PND_SEL_G3 = 6;
    localparam int PND_SEL_G2 = 4;
    localparam int PND_SEL_G1 = 2;
    localparam int PND_SEL_G0 = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PND_PATTERN_RESET = 16'h0000;
    localparam logic [15:0] PND_ENABLE_RESET = 16'h0000;
    localparam logic [15:0] PND_OUTPUT_RESET = 16'h0000;
    localparam logic [7:0] PND_TRIG_SEL_RESET = 8'hff;
    localparam logic [3:0] PND_MODE_RESET = 4'h0;
    localparam logic [3:0] PND_RSVD_NIBBLE = 4'hf;

    // One nibble in a split-layout byte, the idle half reading as ones
    function automatic logic [7:0] pnd_nib_view(input logic [3:0] bits, input logic upper);
        pnd_nib_view = upper ? {bits, PND_RSVD_NIBBLE} : {PND_RSVD_NIBBLE, bits};
    endfunction : pnd_nib_view

endpackage : pnd_pkg

// [core/pnd_trig_sel.sv]
`timescale 1ns/1ps
module pnd_trig_sel (
    input wire logic [pnd_pkg::PND_SEL_W-1:0] sel,
    input wire logic nov,
    input wire logic [3:0] cmp_match_a,
    input wire logic [3:0] cmp_match_b,
    output logic fire
);
    import pnd_pkg::*;

    // ------------------------------------------------------------
    // Channel pick and mode
    // ------------------------------------------------------------
    always_comb begin
        fire = cmp_match_a[sel] | (nov & cmp_match_b[sel]);
    end

endmodule : pnd_trig_sel

// [core/pnd_out_group.sv]
`timescale 1ns/1ps
module pnd_out_group (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic [3:0] enable,
    input wire logic [3:0] staged,
    input wire logic cpu_we,
    input wire logic [3:0] cpu_wdata,
    output logic [3:0] data
);
    import pnd_pkg::*;

    logic [3:0] next_data;

    // ------------------------------------------------------------
    // Output data nibble
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (enable[i]) begin
                next_data[i] = fire ? staged[i] : data[i];
            end else begin
                next_data[i] = cpu_we ? cpu_wdata[i] : data[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data <= PND_OUTPUT_RESET[3:0];
        end else begin
            data <= next_data;
        end
    end

endmodule : pnd_out_group

// [core/pnd_next_data.sv]
// Function
// - Sixteen-bit staging store, cleared at reset
// - Address layout follows shared or split triggers
// - Groups 3/2 shared: high byte one address
// - Groups 3/2 split: high nibbles separate addresses
// - Groups 1/0 shared: low byte one address
// - Groups 1/0 split: low nibbles separate addresses
// - Trigger copies high byte into output data
// - Trigger copies low byte into output data
// - Split layout idle nibble reads ones, ignores writes
// - Only enabled bits transfer on trigger
// - Select codes pick timer channel 0..3
// - Normal mode match A; non-overlap A or B
`timescale 1ns/1ps
module pnd_next_data (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pnd_pkg::PND_ADDR_W-1:0] paddr,
    input wire logic [pnd_pkg::PND_DATA_W-1:0] pwdata,
    output logic [pnd_pkg::PND_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] cmp_match_a,
    input wire logic [3:0] cmp_match_b,
    output logic [15:0] output_data
);
    import pnd_pkg::*;

    logic [15:0] staged;
    logic [15:0] enable;
    logic [7:0] trig_sel;
    logic [3:0] nov;
    logic [31:0] rdata;
    logic rerr;
    logic [15:0] next_staged;
    logic [15:0] next_enable;
    logic [7:0] next_trig_sel;
    logic [3:0] next_nov;
    logic [31:0] next_rdata;
    logic next_rerr;
    logic shared_hi;
    logic shared_lo;
    logic setup;
    logic wr_acc;
    logic addr_ok;
    logic out_we;
    logic [3:0] fire;

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------
    function automatic logic pnd_decode(input logic [7:0] a, input logic sh, input logic sl);
        logic ok;
        ok = 1'b0;
        unique case (a)
            PND_OFF_HIGH: ok = sh;
            PND_OFF_HIGH_UPPER, PND_OFF_HIGH_LOWER: ok = !sh;
            PND_OFF_LOW: ok = sl;
            PND_OFF_LOW_UPPER, PND_OFF_LOW_LOWER: ok = !sl;
            PND_OFF_ENABLE, PND_OFF_TRIG_SEL, PND_OFF_MODE, PND_OFF_OUTPUT: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        pnd_decode = ok;
    endfunction : pnd_decode

    assign shared_hi = trig_sel[PND_SEL_G3+:2] == trig_sel[PND_SEL_G2+:2];
    assign shared_lo = trig_sel[PND_SEL_G1+:2] == trig_sel[PND_SEL_G0+:2];
    assign setup = psel & !penable;
    assign addr_ok = pnd_decode(paddr, shared_hi, shared_lo);
    assign wr_acc = psel & penable & pwrite & addr_ok;
    assign out_we = wr_acc & (paddr == PND_OFF_OUTPUT);
    assign pready = 1'b1;
    assign pslverr = psel & penable & rerr;
    assign prdata = rdata;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    always_comb begin
        next_staged = staged;
        next_enable = enable;
        next_trig_sel = trig_sel;
        next_nov = nov;
        next_rdata = rdata;
        next_rerr = rerr;
        if (wr_acc) begin
            unique case (paddr)
                PND_OFF_HIGH: next_staged[15:8] = pwdata[7:0];
                PND_OFF_HIGH_UPPER: next_staged[15:12] = pwdata[7:4];
                PND_OFF_HIGH_LOWER: next_staged[11:8] = pwdata[3:0];
                PND_OFF_LOW: next_staged[7:0] = pwdata[7:0];
                PND_OFF_LOW_UPPER: next_staged[7:4] = pwdata[7:4];
                PND_OFF_LOW_LOWER: next_staged[3:0] = pwdata[3:0];
                PND_OFF_ENABLE: next_enable = pwdata[15:0];
                PND_OFF_TRIG_SEL: next_trig_sel = pwdata[7:0];
                PND_OFF_MODE: next_nov = pwdata[3:0];
                default: next_nov = nov;
            endcase
        end
        if (setup) begin
            next_rerr = !addr_ok;
            next_rdata = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    PND_OFF_HIGH: next_rdata[7:0] = shared_hi ? staged[15:8] : 8'h00;
                    PND_OFF_HIGH_UPPER: next_rdata[7:0] = pnd_nib_view(staged[15:12], 1'b1);
                    PND_OFF_HIGH_LOWER: next_rdata[7:0] = pnd_nib_view(staged[11:8], 1'b0);
                    PND_OFF_LOW: next_rdata[7:0] = shared_lo ? staged[7:0] : 8'h00;
                    PND_OFF_LOW_UPPER: next_rdata[7:0] = pnd_nib_view(staged[7:4], 1'b1);
                    PND_OFF_LOW_LOWER: next_rdata[7:0] = pnd_nib_view(staged[3:0], 1'b0);
                    PND_OFF_ENABLE: next_rdata[15:0] = enable;
                    PND_OFF_TRIG_SEL: next_rdata[7:0] = trig_sel;
                    PND_OFF_MODE: next_rdata[3:0] = nov;
                    PND_OFF_OUTPUT: next_rdata[15:0] = output_data;
                    default: next_rdata = 32'h0000_0000;
                endcase
                if (!addr_ok) begin
                    next_rdata = 32'h0000_0000;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            staged <= PND_PATTERN_RESET;
            enable <= PND_ENABLE_RESET;
            trig_sel <= PND_TRIG_SEL_RESET;
            nov <= PND_MODE_RESET;
            rdata <= 32'h0000_0000;
            rerr <= 1'b0;
        end else begin
            staged <= next_staged;
            enable <= next_enable;
            trig_sel <= next_trig_sel;
            nov <= next_nov;
            rdata <= next_rdata;
            rerr <= next_rerr;
        end
    end

    // ------------------------------------------------------------
    // Trigger selection and output data
    // ------------------------------------------------------------
    for (genvar g = 0; g < PND_GROUPS; g++) begin : g_group
        pnd_trig_sel u_trig (
            .sel(trig_sel[PND_SEL_W*g+:PND_SEL_W]),
            .nov(nov[g]),
            .cmp_match_a(cmp_match_a),
            .cmp_match_b(cmp_match_b),
            .fire(fire[g])
        );
        pnd_out_group u_out (
            .pclk(pclk),
            .presetn(presetn),
            .fire(fire[g]),
            .enable(enable[4*g+:4]),
            .staged(staged[4*g+:4]),
            .cpu_we(out_we),
            .cpu_wdata(pwdata[4*g+:4]),
            .data(output_data[4*g+:4])
        );
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_reset_clear;
        @(posedge pclk) $rose(presetn) |-> (staged == 16'h0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Store not clear after reset");

    property p_shared_high_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == PND_OFF_HIGH && shared_hi)
            |=> (staged[15:8] == $past(pwdata[7:0]));
    endproperty
    a_shared_high_write: assert property (p_shared_high_write) else $error("High byte write lost");

    property p_split_high_upper;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == PND_OFF_HIGH_UPPER && !shared_hi)
            |=> (staged[15:12] == $past(pwdata[7:4])) && $stable(staged[11:8]);
    endproperty
    a_split_high_upper: assert property (p_split_high_upper) else $error("Upper nibble write bad");

    property p_shared_low_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == PND_OFF_LOW && shared_lo)
            |=> (staged[7:0] == $past(pwdata[7:0]));
    endproperty
    a_shared_low_write: assert property (p_shared_low_write) else $error("Low byte write lost");

    property p_split_low_lower;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == PND_OFF_LOW_LOWER && !shared_lo)
            |=> (staged[3:0] == $past(pwdata[3:0])) && $stable(staged[7:4]);
    endproperty
    a_split_low_lower: assert property (p_split_low_lower) else $error("Lower nibble write bad");

    property p_xfer_high;
        @(posedge pclk) disable iff (!presetn)
        (fire[3] && enable[15]) |=> (output_data[15] == $past(staged[15]));
    endproperty
    a_xfer_high: assert property (p_xfer_high) else $error("High bit not transferred");

    property p_xfer_low;
        @(posedge pclk) disable iff (!presetn)
        (fire[0] && enable[0]) |=> (output_data[0] == $past(staged[0]));
    endproperty
    a_xfer_low: assert property (p_xfer_low) else $error("Low bit not transferred");

    property p_reserved_ones;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == PND_OFF_HIGH_UPPER && !shared_hi)
            ##1 (psel && penable) |-> (prdata[3:0] == 4'hf);
    endproperty
    a_reserved_ones: assert property (p_reserved_ones) else $error("Idle nibble not ones");

    property p_disabled_hold;
        @(posedge pclk) disable iff (!presetn)
        (!enable[0] && !out_we) |=> $stable(output_data[0]);
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) else $error("Disabled bit changed");

    property p_trigger_pick;
        @(posedge pclk) disable iff (!presetn)
        fire[1] == (cmp_match_a[trig_sel[3:2]] || (nov[1] && cmp_match_b[trig_sel[3:2]]));
    endproperty
    a_trigger_pick: assert property (p_trigger_pick) else $error("Wrong trigger source");

    property p_layout_follow;
        @(posedge pclk) disable iff (!presetn)
        (setup && paddr == PND_OFF_HIGH && trig_sel[7:6] != trig_sel[5:4])
            ##1 (psel && penable) |-> pslverr;
    endproperty
    a_layout_follow: assert property (p_layout_follow) else $error("Shared address open when split");

    c_split_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == PND_OFF_HIGH_LOWER);
    c_shared_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == PND_OFF_LOW);
    c_transfer: cover property (@(posedge pclk) disable iff (!presetn)
        fire[2] && enable[11:8] != 4'h0);
    c_nonoverlap: cover property (@(posedge pclk) disable iff (!presetn)
        nov[0] && cmp_match_b[trig_sel[1:0]] && !cmp_match_a[trig_sel[1:0]]);

endmodule : pnd_next_data

// [verification/pnd_timer_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Timer compare-match source
// ------------------------------------------------------------
module pnd_timer_model (
    input wire logic pclk,
    output logic [3:0] cmp_match_a,
    output logic [3:0] cmp_match_b
);
    initial begin
        cmp_match_a = 4'h0;
        cmp_match_b = 4'h0;
    end

    // One-cycle match pulse on channel ch, A or B
    task automatic fire(input int ch, input logic on_b);
        @(posedge pclk);
        if (on_b) begin
            cmp_match_b[ch] <= 1'b1;
        end else begin
            cmp_match_a[ch] <= 1'b1;
        end
        @(posedge pclk);
        cmp_match_a <= 4'h0;
        cmp_match_b <= 4'h0;
    endtask : fire
endmodule : pnd_timer_model

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import pnd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] cmp_match_a;
    logic [3:0] cmp_match_b;
    logic [15:0] output_data;
    int n_errors = 0;
    int samples_checked = 0;

    always #50 pclk = ~pclk;

    pnd_next_data uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_match_a(cmp_match_a),
        .cmp_match_b(cmp_match_b), .output_data(output_data)
    );

    pnd_timer_model tm (
        .pclk(pclk), .cmp_match_a(cmp_match_a), .cmp_match_b(cmp_match_b)
    );

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // ------------------------------------------------------------
    // APB access: read checks data v, write sends v
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] v,
                        input logic ee);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? v : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("mismatch pready expected 1 seen %b", pready);
            results();
        end
        chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
        if (!wr) begin
            chk("prdata", v, prdata);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never reassigns psel in this step
        @(posedge pclk);
    endtask : xfer

    // Fire one match, then check the output pins
    task automatic fchk(input int ch, input logic on_b, input logic [15:0] exp);
        tm.fire(ch, on_b);
        @(negedge pclk);
        chk("output_data", {16'h0, exp}, {16'h0, output_data});
        @(posedge pclk);
    endtask : fchk

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk("output_data", 32'h0, {16'h0, output_data});
        @(posedge pclk);
        xfer(1'b0, PND_OFF_HIGH, 32'h0, 1'b0);
        xfer(1'b0, PND_OFF_LOW, 32'h0, 1'b0);
        xfer(1'b0, PND_OFF_TRIG_SEL, 32'hff, 1'b0);
        xfer(1'b0, PND_OFF_HIGH_UPPER, 32'h0, 1'b1);
        xfer(1'b1, PND_OFF_HIGH, 32'ha5, 1'b0);
        xfer(1'b0, PND_OFF_HIGH, 32'ha5, 1'b0);
        xfer(1'b1, PND_OFF_LOW, 32'h3c, 1'b0);
        xfer(1'b0, PND_OFF_LOW, 32'h3c, 1'b0);
        xfer(1'b1, PND_OFF_TRIG_SEL, 32'he4, 1'b0);
        xfer(1'b0, PND_OFF_HIGH, 32'h0, 1'b1);
        xfer(1'b0, PND_OFF_HIGH_UPPER, 32'haf, 1'b0);
        xfer(1'b0, PND_OFF_HIGH_LOWER, 32'hf5, 1'b0);
        xfer(1'b0, PND_OFF_LOW_UPPER, 32'h3f, 1'b0);
        xfer(1'b0, PND_OFF_LOW_LOWER, 32'hfc, 1'b0);
        xfer(1'b1, PND_OFF_HIGH_UPPER, 32'h6b, 1'b0);
        xfer(1'b1, PND_OFF_HIGH_LOWER, 32'h02, 1'b0);
        xfer(1'b1, PND_OFF_LOW_UPPER, 32'h90, 1'b0);
        xfer(1'b1, PND_OFF_LOW_LOWER, 32'ha7, 1'b0);
        xfer(1'b0, PND_OFF_HIGH_UPPER, 32'h6f, 1'b0);
        xfer(1'b0, PND_OFF_HIGH_LOWER, 32'hf2, 1'b0);
        xfer(1'b0, PND_OFF_LOW_UPPER, 32'h9f, 1'b0);
        xfer(1'b0, PND_OFF_LOW_LOWER, 32'hf7, 1'b0);
        xfer(1'b0, 8'h30, 32'h0, 1'b1);
        xfer(1'b1, PND_OFF_HIGH, 32'h11, 1'b1);
        xfer(1'b1, PND_OFF_ENABLE, 32'hff0f, 1'b0);
        xfer(1'b1, PND_OFF_OUTPUT, 32'hffff, 1'b0);
        @(negedge pclk);
        chk("output_data", 32'h00f0, {16'h0, output_data});
        @(posedge pclk);
        fchk(0, 1'b1, 16'h00f0);
        fchk(0, 1'b0, 16'h00f7);
        fchk(1, 1'b0, 16'h00f7);
        fchk(2, 1'b0, 16'h02f7);
        fchk(3, 1'b0, 16'h62f7);
        xfer(1'b1, PND_OFF_MODE, 32'h1, 1'b0);
        xfer(1'b1, PND_OFF_LOW_LOWER, 32'h0b, 1'b0);
        fchk(0, 1'b1, 16'h62fb);
        xfer(1'b1, PND_OFF_TRIG_SEL, 32'hff, 1'b0);
        xfer(1'b0, PND_OFF_HIGH, 32'h62, 1'b0);
        xfer(1'b0, PND_OFF_LOW, 32'h9b, 1'b0);
        xfer(1'b0, PND_OFF_LOW_LOWER, 32'h0, 1'b1);
        xfer(1'b0, PND_OFF_OUTPUT, 32'h62fb, 1'b0);
        xfer(1'b0, PND_OFF_ENABLE, 32'hff0f, 1'b0);
        xfer(1'b0, PND_OFF_MODE, 32'h1, 1'b0);
        results();
    end
endmodule : testbench
